// ===== hw/bsinit_pkg.sv
// bootstrap init status and high-side/low-side coupling: shared constants and types
// assumes a 40 MHz system clock and a 16-bit register port with 10-bit addresses
package bsinit_pkg;

   localparam int          NUM_HS        = 5;
   localparam int          NUM_LS        = 7;
   localparam int          NUM_LINK_HS   = 2;

   localparam logic [9:0]  ADDR_STATUS   = 10'h1A5;
   localparam logic [9:0]  ADDR_COUPLING = 10'h1A6;

   // status register layout
   localparam int          TIMER_LSB     = 10;
   localparam int          RAISED_LSB    = 5;
   localparam int          PENDING_LSB   = 0;

   // coupling register layout, per high-side a byte
   localparam int          SEL_LSB_HS1   = 0;
   localparam int          OVR_BIT_HS1   = 7;
   localparam int          SEL_LSB_HS2   = 8;
   localparam int          OVR_BIT_HS2   = 15;

   localparam logic [15:0] COUPLING_RST  = 16'h7F7F;
   localparam logic [4:0]  PENDING_RST   = 5'h1F;
   localparam logic [4:0]  RAISED_RST    = 5'h00;
   localparam logic [5:0]  TIMER_RST     = 6'h00;
   localparam logic [5:0]  TIMER_FINAL   = 6'h34;

   // timing
   localparam longint      CLK_PERIOD_PS = 25000;
   localparam longint      STEP_TIME_PS  = 681250000;
   localparam longint      END_TIME_MS   = 36;
   localparam longint      STEP_CYCLES   = (STEP_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam longint      END_CYCLES    =
      (END_TIME_MS * 64'd1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // analog sense inputs of all high-side pre-drivers
   typedef struct packed {
      logic [NUM_HS-1:0] ready_cmp;
      logic [NUM_HS-1:0] clamp_on;
      logic [NUM_HS-1:0] src_below;
      logic [NUM_HS-1:0] hs_on;
   } bsinit_sense_t;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [9:0]  addr;
      logic [15:0] wdata;
   } bsinit_req_t;

endpackage

// ===== hw/bsinit_top.sv
// bootstrap initialization status register and hs1/hs2 low-side coupling register
// assumes sense inputs and register requests are synchronous to mclk
//
// Notes on behaviour
// - pending flag clears when capacitor charged
// - raised flag set when 1.0 V needed
// - timer field shows six MSBs, resets zero
// - flag pair encodes charge and threshold state
// - timer field zero until supply undervoltage first ends
// - field step one is about 0.68 ms
// - 100000 is 21.8 ms, 110011 34.7 ms
// - final 110100 at 36 ms, together with 1.0 V
// - link active when any selected low-side on
// - override forces link active to disabled level
// - coupling bit layout, override resets zero, lockable
// - one global timer starts after undervoltage, 36 ms
// - at end count, pending drivers raise threshold
// - init ends on charge, clamp, link, switch-on
`timescale 1ns/10ps
module bsinit_top #(
   parameter int unsigned STEP_CYC = 32'(bsinit_pkg::STEP_CYCLES),
   parameter int unsigned END_CYC  = 32'(bsinit_pkg::END_CYCLES)
) (
   input  wire logic                           mclk,
   input  wire logic                           rst_b,
   input  wire logic                           gate_supply_undervoltage,
   input  wire bsinit_pkg::bsinit_sense_t      sense,
   input  wire logic [bsinit_pkg::NUM_LS-1:0]  lowside_on,
   input  wire logic                           reg_lock,
   input  wire bsinit_pkg::bsinit_req_t        req,
   output logic [15:0]                         reg_rdata,
   output logic                                reg_rvalid,
   output logic [bsinit_pkg::NUM_LINK_HS-1:0]  lowside_link_active,
   output logic [bsinit_pkg::NUM_HS-1:0]       source_threshold_raised,
   output logic [bsinit_pkg::NUM_HS-1:0]       bootstrap_pending_flag,
   output logic [bsinit_pkg::NUM_HS-1:0]       threshold_1v_sel
);

   logic        started;
   logic        expired;
   logic [20:0] run_cnt;
   logic [19:0] step_cnt;
   logic [5:0]  timer_field;
   logic [15:0] coupling;
   logic [6:0]  sel [bsinit_pkg::NUM_LINK_HS];
   logic [bsinit_pkg::NUM_LINK_HS-1:0] ovr;
   logic [bsinit_pkg::NUM_HS-1:0]      link_term;
   logic [bsinit_pkg::NUM_HS-1:0]      init_end;
   logic        expiry_pulse;
   logic [15:0] next_rdata;

   assign sel[0] = coupling[bsinit_pkg::SEL_LSB_HS1 +: 7];
   assign sel[1] = coupling[bsinit_pkg::SEL_LSB_HS2 +: 7];
   assign ovr[0] = coupling[bsinit_pkg::OVR_BIT_HS1];
   assign ovr[1] = coupling[bsinit_pkg::OVR_BIT_HS2];

   // timer start latch: a later undervoltage does not restart it
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         started <= 1'b0;
      else if (!gate_supply_undervoltage)
         started <= 1'b1;
   end

   assign expiry_pulse = started && !expired && (run_cnt == 21'(END_CYC - 1));

   // global end-of-count counter
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         run_cnt <= '0;
         expired <= 1'b0;
      end
      else if (expiry_pulse)
         expired <= 1'b1;
      else if (started && !expired)
         run_cnt <= run_cnt + 21'h000001;
   end

   // visible six-bit field; stepping stops one code short of final, the
   // final code only follows the end count so it never shows before 1.0 V
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         step_cnt    <= '0;
         timer_field <= bsinit_pkg::TIMER_RST;
      end
      else if (expiry_pulse)
         timer_field <= bsinit_pkg::TIMER_FINAL;
      else if (started && timer_field < (bsinit_pkg::TIMER_FINAL - 6'h01))
      begin
         if (step_cnt == 20'(STEP_CYC - 1))
         begin
            step_cnt    <= '0;
            timer_field <= timer_field + 6'h01;
         end
         else
            step_cnt <= step_cnt + 20'h00001;
      end
   end

   // coupling register, writable only while unlocked
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         coupling <= bsinit_pkg::COUPLING_RST;
      else if (req.wr && !reg_lock && req.addr == bsinit_pkg::ADDR_COUPLING)
         coupling <= req.wdata;
   end

   // override forces the disabled (high) level, which also ends init
   generate
      for (genvar h = 0; h < bsinit_pkg::NUM_LINK_HS; h++)
      begin : g_link
         always_ff @(posedge mclk or negedge rst_b)
         begin
            if (!rst_b)
               lowside_link_active[h] <= 1'b0;
            else
               lowside_link_active[h] <= ovr[h] | (|(sel[h] & lowside_on));
         end
      end
   endgenerate

   assign link_term = {{(bsinit_pkg::NUM_HS - bsinit_pkg::NUM_LINK_HS){1'b0}},
                       lowside_link_active};

   // per high-side init state
   generate
      for (genvar i = 0; i < bsinit_pkg::NUM_HS; i++)
      begin : g_hs
         assign init_end[i] = (sense.ready_cmp[i] & sense.src_below[i])
                            | (sense.clamp_on[i] & sense.src_below[i])
                            | link_term[i] | sense.hs_on[i];

         always_ff @(posedge mclk or negedge rst_b)
         begin
            if (!rst_b)
               bootstrap_pending_flag[i] <= bsinit_pkg::PENDING_RST[i];
            else if (started && init_end[i])
               bootstrap_pending_flag[i] <= 1'b0;
         end

         // raised is sampled at the end count only for drivers still pending
         always_ff @(posedge mclk or negedge rst_b)
         begin
            if (!rst_b)
               source_threshold_raised[i] <= bsinit_pkg::RAISED_RST[i];
            else if (expiry_pulse && bootstrap_pending_flag[i])
               source_threshold_raised[i] <= 1'b1;
         end

         always_ff @(posedge mclk or negedge rst_b)
         begin
            if (!rst_b)
               threshold_1v_sel[i] <= 1'b0;
            else
               threshold_1v_sel[i] <= (expired | expiry_pulse) & bootstrap_pending_flag[i]
                                      & ~(started & init_end[i]);
         end
      end
   endgenerate

   always_comb
   begin
      next_rdata = 16'h0000;
      if (req.addr == bsinit_pkg::ADDR_STATUS)
      begin
         next_rdata[bsinit_pkg::TIMER_LSB +: 6]   = timer_field;
         next_rdata[bsinit_pkg::RAISED_LSB +: 5]  = source_threshold_raised;
         next_rdata[bsinit_pkg::PENDING_LSB +: 5] = bootstrap_pending_flag;
      end
      else if (req.addr == bsinit_pkg::ADDR_COUPLING)
         next_rdata = coupling;
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         reg_rdata  <= 16'h0000;
         reg_rvalid <= 1'b0;
      end
      else
      begin
         reg_rvalid <= req.rd;
         if (req.rd)
            reg_rdata <= next_rdata;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   timer_zero_uv_a: assert property (!started |-> timer_field == 6'h00)
      else $error("timer field nonzero before supply stable");
   timer_hold_a: assert property (expired |=> timer_field == 6'h34 && $stable(timer_field))
      else $error("timer field moved after expiry");
   timer_step_a: assert property (timer_field != $past(timer_field) |->
                                  timer_field == $past(timer_field) + 6'h01)
      else $error("timer field skipped a code");
   raise_at_end_a: assert property (expiry_pulse && bootstrap_pending_flag[1] |=>
                                    source_threshold_raised[1])
      else $error("pending driver not raised at end count");
   raise_only_end_a: assert property ($rose(source_threshold_raised[1]) |->
                                      $past(expiry_pulse))
      else $error("raised flag set outside end count");
   pending_clear_a: assert property (started && bootstrap_pending_flag[2] && sense.hs_on[2] |=>
                                     !bootstrap_pending_flag[2])
      else $error("init did not end on switch-on");
   pending_sticky_a: assert property (!bootstrap_pending_flag[3] |=> !bootstrap_pending_flag[3])
      else $error("charged flag returned to pending");
   link_ovr_a: assert property (ovr[0] |=> lowside_link_active[0])
      else $error("override did not force link active");
   link_any_a: assert property (|(sel[1] & lowside_on) |=> lowside_link_active[1])
      else $error("selected low-side on but link inactive");
   link_idle_a: assert property (!ovr[0] && !(|(sel[0] & lowside_on)) |=> !lowside_link_active[0])
      else $error("link active with no cause");
   lock_write_a: assert property (reg_lock |=> $stable(coupling))
      else $error("coupling changed while locked");

   expire_c: cover property (expiry_pulse);
   raised_c: cover property (expiry_pulse && bootstrap_pending_flag[4]);
   charged_c: cover property (started && sense.ready_cmp[4] && sense.src_below[4]);
   write_c: cover property (req.wr && !reg_lock && req.addr == bsinit_pkg::ADDR_COUPLING);

endmodule // bsinit_top

// ===== test/bsinit_host.sv
// host model: issues register reads and writes on the request port
// assumes one-cycle request strobes sampled on rising mclk
`timescale 1ns/10ps
module bsinit_host (
   input  wire logic                  mclk,
   input  wire logic [15:0]           reg_rdata,
   input  wire logic                  reg_rvalid,
   output bsinit_pkg::bsinit_req_t    req
);
   initial req = '0;

   // select bits chosen by software to match shared loads
   task automatic wr(input logic [9:0] a, input logic [15:0] d);
      @(negedge mclk);
      req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(negedge mclk);
      // released bus shows the inverse, not stale data
      req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
   endtask

   // status read combined with flags by software
   task automatic rd(input logic [9:0] a, output logic [15:0] d);
      @(negedge mclk);
      req.rd = 1'b1;
      req.addr = a;
      @(negedge mclk);
      req.rd = 1'b0;
      req.addr = ~a;
      d = (reg_rvalid === 1'b1) ? reg_rdata : 16'hXXXX;
   endtask
endmodule // bsinit_host

// ===== test/bsinit_tb_top.sv
// testbench: register, coupling and init timer checks with short timer counts
// assumes the host model drives the request port
`timescale 1ns/10ps
module bsinit_tb_top;
   logic                      mclk;
   logic                      rst_b;
   logic                      gate_supply_undervoltage;
   bsinit_pkg::bsinit_sense_t sense;
   logic [6:0]                lowside_on;
   logic                      reg_lock;
   bsinit_pkg::bsinit_req_t   req;
   logic [15:0]               reg_rdata;
   logic                      reg_rvalid;
   logic [1:0]                link;
   logic [4:0]                raised;
   logic [4:0]                pending;
   logic [4:0]                thr_sel;
   logic [15:0]               d;
   int                        fail_count;
   int                        n_tests;
   int                        cyc;

   bsinit_top #(.STEP_CYC(4), .END_CYC(220)) dut (
      .mclk                    (mclk),
      .rst_b                   (rst_b),
      .gate_supply_undervoltage(gate_supply_undervoltage),
      .sense                   (sense),
      .lowside_on              (lowside_on),
      .reg_lock                (reg_lock),
      .req                     (req),
      .reg_rdata               (reg_rdata),
      .reg_rvalid              (reg_rvalid),
      .lowside_link_active     (link),
      .source_threshold_raised (raised),
      .bootstrap_pending_flag  (pending),
      .threshold_1v_sel        (thr_sel)
   );

   bsinit_host host (
      .mclk      (mclk),
      .reg_rdata (reg_rdata),
      .reg_rvalid(reg_rvalid),
      .req       (req)
   );

   always #12.5 mclk = ~mclk;

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ceiling well above the roughly 510 cycles of the sequence
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         fail_count++;
         results();
      end
   end

   initial
   begin
      mclk = 1'b0;
      rst_b = 1'b0;
      gate_supply_undervoltage = 1'b1;
      sense = '0;
      lowside_on = 7'h00;
      reg_lock = 1'b0;
      fail_count = 0;
      n_tests = 0;
      cyc = 0;
      repeat (4) @(negedge mclk);
      rst_b = 1'b1;
      // switch-on before the supply is stable must not end init
      sense.hs_on = 5'h1F;
      repeat (50) @(negedge mclk);
      host.rd(bsinit_pkg::ADDR_STATUS, d);
      chk(d, 16'h001F);
      sense.hs_on = 5'h00;
      host.rd(bsinit_pkg::ADDR_COUPLING, d);
      chk(d, 16'h7F7F);
      chk({14'h0, link}, 16'h0000);
      lowside_on = 7'h04;
      @(negedge mclk);
      chk({14'h0, link}, 16'h0003);
      $display("test reset and link done");
      host.wr(bsinit_pkg::ADDR_COUPLING, 16'h0080);
      lowside_on = 7'h7F;
      @(negedge mclk);
      chk({14'h0, link}, 16'h0001);
      reg_lock = 1'b1;
      host.wr(bsinit_pkg::ADDR_COUPLING, 16'h7F7F);
      reg_lock = 1'b0;
      host.wr(bsinit_pkg::ADDR_STATUS, 16'hFFFF);
      host.rd(bsinit_pkg::ADDR_COUPLING, d);
      chk(d, 16'h0080);
      host.rd(10'h3FF, d);
      chk(d, 16'h0000);
      $display("test override and lock done");
      lowside_on = 7'h00;
      gate_supply_undervoltage = 1'b0;
      repeat (130) @(negedge mclk);
      host.rd(bsinit_pkg::ADDR_STATUS, d);
      chk(d, 16'h801E);
      // just before the end count the field must still sit below the final code
      repeat (80) @(negedge mclk);
      host.rd(bsinit_pkg::ADDR_STATUS, d);
      chk(d, 16'hCC1E);
      chk({11'h0, thr_sel}, 16'h0000);
      repeat (217) @(negedge mclk);
      host.rd(bsinit_pkg::ADDR_STATUS, d);
      chk(d, 16'hD3DE);
      chk({11'h0, thr_sel}, 16'h001E);
      // one end condition per driver; driver 1 comparator alone must not end init
      sense.hs_on[2]     = 1'b1;
      sense.clamp_on[3]  = 1'b1;
      sense.src_below[3] = 1'b1;
      sense.ready_cmp[4] = 1'b1;
      sense.src_below[4] = 1'b1;
      sense.ready_cmp[1] = 1'b1;
      repeat (3) @(negedge mclk);
      // late undervoltage must not disturb the held timer
      gate_supply_undervoltage = 1'b1;
      repeat (3) @(negedge mclk);
      host.rd(bsinit_pkg::ADDR_STATUS, d);
      chk(d, 16'hD3C2);
      chk({6'h0, raised, pending}, 16'h03C2);
      chk({11'h0, thr_sel}, 16'h0002);
      $display("test init timer done");
      results();
   end
endmodule // bsinit_tb_top
